// [core/jcr_cfg_mem.sv]
`timescale 1ns/1ns
module jcr_cfg_mem
    import jcr_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    // write port
    input wire logic we_i,
    input wire logic [MEM_AW-1:0] waddr_i,
    input wire logic [WORD_W-1:0] wdata_i,
    // read port
    input wire logic [MEM_AW-1:0] raddr_i,
    output logic [WORD_W-1:0] rdata_o
);
    logic [WORD_W-1:0] mem [0:MEM_DEPTH-1];
    logic [WORD_W-1:0] next_rdata;

    always_comb begin
        next_rdata = mem[raddr_i];
    end

    // no clear port: frames survive a reload so partial reconfiguration works
    always_ff @(posedge clk_sys_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        if (!rstn_i) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= next_rdata;
        end
    end
endmodule : jcr_cfg_mem

// [core/jcr_config_port.sv]
// Register access over AHB-Lite and the register offsets are this design's own decisions.
`timescale 1ns/1ns
module jcr_config_port
    import jcr_pkg::*;
(
    // system
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    // test port pins
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    input wire logic program_n_i,
    output logic tdo_o,
    output logic tdo_oe_o,
    // configuration status pins
    output logic done_o,
    output logic init_n_o,
    output logic init_n_oe_o,
    output logic global_high_o,
    // ahb-lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o
);
    jcr_pins_type pins_raw;
    jcr_pins_type pins;
    jcr_eng_type r;
    jcr_eng_type n;
    jcr_ahb_type a;
    jcr_ahb_type an;
    jcr_hdr_type hdr;
    logic tck_rise;
    logic tck_fall;
    logic prog;
    logic startup_fire;
    logic mem_we;
    logic [31:0] mem_rdata;
    logic [31:0] stat_word;

    assign pins_raw = {tck_i, tms_i, tdi_i, program_n_i};

    jcr_sync #(.W($bits(jcr_pins_type))) u_sync (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .d_i(pins_raw),
        .q_o(pins)
    );

    jcr_cfg_mem u_mem (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .we_i(mem_we),
        .waddr_i(r.frame_address_register),
        .wdata_i(r.word_sh),
        .raddr_i(r.rb_addr),
        .rdata_o(mem_rdata)
    );

    // tck is 8 system clocks per period, so edges are found by sampling
    assign tck_rise = pins.tck & ~r.tck_q;
    assign tck_fall = ~pins.tck & r.tck_q;
    assign prog = ~pins.program_n;
    assign hdr = r.word_sh;

    always_comb begin
        stat_word = {16'h0000, STAT_CONST};
        stat_word[STAT_CRC_BIT] = r.crc_err;
        stat_word[STAT_ACTIVE_BIT] = r.active;
        stat_word[STAT_GHIGH_N_BIT] = ~r.ghigh;
        stat_word[STAT_INIT_BIT] = ~r.init_oe;
        stat_word[STAT_DONE_BIT] = r.done;
    end

    always_comb begin
        n = r;
        n.tck_q = pins.tck;
        n.word_valid = 1'b0;
        n.init_oe = prog;
        startup_fire = 1'b0;
        mem_we = 1'b0;
        if (tck_rise) begin
            n.tap_state = tap_next(r.tap_state, pins.tms);
            unique case (r.tap_state)
                TAP_TLR: begin
                    n.ir = IR_BYPASS;
                end
                TAP_CAP_IR: begin
                    n.ir_sh = IR_CAPTURE;
                end
                TAP_SH_IR: begin
                    n.ir_sh = {pins.tdi, r.ir_sh[IR_W-1:1]};
                end
                TAP_UPD_IR: begin
                    n.ir = r.ir_sh;
                end
                TAP_CAP_DR: begin
                    n.bit_cnt = '0;
                    n.byp = 1'b0;
                    n.start_cnt = '0;
                    if (r.ir == IR_CFG_OUT) begin
                        // captured word is the first of 1 + frame_words leading garbage words unless status was asked for
                        n.out_sh = r.rd_stat ? stat_word : '0;
                        n.gar_cnt = r.rd_stat ? 8'h00 : a.frame_words;
                    end
                end
                TAP_SH_DR: begin
                    n.bit_cnt = r.bit_cnt + 5'h01;
                    n.byp = pins.tdi;
                    n.word_sh = {r.word_sh[30:0], pins.tdi};
                    n.out_sh = {r.out_sh[30:0], 1'b0};
                    if (r.ir == IR_CFG_IN && r.bit_cnt == 5'h1F) begin
                        n.word_valid = 1'b1;
                    end
                    if (r.ir == IR_CFG_OUT && r.bit_cnt == 5'h1F) begin
                        if (r.gar_cnt != 8'h00) begin
                            n.out_sh = '0;
                            n.gar_cnt = r.gar_cnt - 8'h01;
                        end else if (r.rb_left != 11'h000) begin
                            n.out_sh = mem_rdata;
                            n.rb_left = r.rb_left - 11'h001;
                            n.rb_addr = r.rb_addr + 8'h01;
                        end else begin
                            n.out_sh = '0;
                        end
                    end
                    if (r.ir == IR_STARTUP && r.start_cnt != STARTUP_CLKS) begin
                        n.start_cnt = r.start_cnt + 4'h1;
                        startup_fire = (r.start_cnt == STARTUP_CLKS - 4'h1);
                    end
                end
                default: begin
                end
            endcase
        end
        if (startup_fire) begin
            if (r.shutdown) begin
                n.active = 1'b0;
                n.done = 1'b0;
            end else if (r.start_seen && !r.crc_err) begin
                n.active = 1'b1;
                n.done = 1'b1;
                n.ghigh = 1'b0;
                n.start_seen = 1'b0;
            end
        end
        if (tck_fall) begin
            n.tdo_oe = (r.tap_state == TAP_SH_DR) || (r.tap_state == TAP_SH_IR);
            if (r.tap_state == TAP_SH_IR) begin
                n.tdo = r.ir_sh[0];
            end else if (r.ir == IR_CFG_OUT) begin
                n.tdo = r.out_sh[31];
            end else begin
                n.tdo = r.byp;
            end
        end
        // packet processor: zero words while idle are padding and are dropped
        if (r.word_valid) begin
            if (r.pp_left == 11'h000) begin
                if (hdr.kind == HDR_TYPE1 && hdr.op == OP_WRITE) begin
                    n.pp_addr = hdr.addr;
                    n.pp_left = hdr.count;
                end else if (hdr.kind == HDR_TYPE1 && hdr.op == OP_READ) begin
                    if (hdr.addr == REG_STAT) begin
                        n.rd_stat = 1'b1;
                    end else if (hdr.addr == REG_FRAME_OUT && r.rd_cfg) begin
                        n.rd_stat = 1'b0;
                        n.rb_left = hdr.count;
                        n.rb_addr = r.frame_address_register;
                    end
                end
            end else begin
                n.pp_left = r.pp_left - 11'h001;
                n.crc = crc_step(r.crc, r.word_sh);
                unique case (r.pp_addr)
                    REG_CRC: begin
                        n.crc = '0;
                        if (r.word_sh != r.crc) begin
                            n.crc_err = 1'b1;
                        end
                    end
                    REG_FAR: begin
                        n.frame_address_register = r.word_sh[MEM_AW-1:0];
                    end
                    REG_FDRI: begin
                        if (r.wcfg) begin
                            mem_we = 1'b1;
                            n.frame_address_register = r.frame_address_register + 8'h01;
                        end
                    end
                    REG_CMD: begin
                        unique case (r.word_sh[3:0])
                            CMD_WCFG: begin
                                n.wcfg = 1'b1;
                                n.rd_cfg = 1'b0;
                            end
                            CMD_READ_CFG: begin
                                n.rd_cfg = 1'b1;
                                n.wcfg = 1'b0;
                            end
                            CMD_START: begin
                                n.start_seen = 1'b1;
                            end
                            CMD_CRC_RESET: begin
                                n.crc = '0;
                                n.crc_err = 1'b0;
                            end
                            CMD_GLOBAL_HIGH: begin
                                n.ghigh = 1'b1;
                            end
                            default: begin
                            end
                        endcase
                    end
                    REG_OPTION: begin
                        n.shutdown = r.word_sh[OPT_SHUTDOWN_BIT];
                    end
                    default: begin
                    end
                endcase
            end
        end
        // program low: restart configuration, hold the tap in reset, keep memory contents
        if (prog) begin
            n.tap_state = TAP_TLR;
            n.ir = IR_BYPASS;
            n.tdo_oe = 1'b0;
            n.pp_left = '0;
            n.rb_left = '0;
            n.crc = '0;
            n.crc_err = 1'b0;
            n.wcfg = 1'b0;
            n.rd_cfg = 1'b0;
            n.start_seen = 1'b0;
            n.shutdown = 1'b0;
            n.active = 1'b0;
            n.done = 1'b0;
            n.ghigh = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            r <= ENG_RESET;
        end else begin
            r <= n;
        end
    end

    // zero wait state slave; read data latched in the address phase
    always_comb begin
        an = a;
        an.dp_valid = hsel_i && hready_i && htrans_i[1];
        an.dp_write = hwrite_i;
        an.dp_addr = haddr_i[7:0];
        if (a.dp_valid && a.dp_write && a.dp_addr == ADDR_CTRL) begin
            an.frame_words = hwdata_i[7:0];
        end
        if (an.dp_valid && !hwrite_i) begin
            an.hrdata = '0;
            if (haddr_i[31:8] == 24'h000000) begin
                unique case (haddr_i[7:0])
                    ADDR_CTRL: begin
                        an.hrdata = {24'h000000, an.frame_words};
                    end
                    ADDR_STATUS: begin
                        an.hrdata = {11'h000, r.ir, 4'h0, r.tap_state, 2'h0, ~r.init_oe, r.start_seen,
                            r.shutdown, r.ghigh, r.crc_err, r.done};
                    end
                    ADDR_FAR: begin
                        an.hrdata = {24'h000000, r.frame_address_register};
                    end
                    default: begin
                        an.hrdata = '0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            a <= AHB_RESET;
        end else begin
            a <= an;
        end
    end

    assign hrdata_o = a.hrdata;
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign tdo_o = r.tdo;
    assign tdo_oe_o = r.tdo_oe;
    assign done_o = r.done;
    assign init_n_o = 1'b0;
    // init only pulls low during program, never on a checksum error
    assign init_n_oe_o = r.init_oe;
    assign global_high_o = r.ghigh;
endmodule : jcr_config_port

// [core/jcr_pkg.sv]
package jcr_pkg;

    // data path widths and memory depth
    localparam int WORD_W = 32;
    localparam int MEM_AW = 8;
    localparam int MEM_DEPTH = 256;
    localparam int IR_W = 5;

    // instruction codes as held in the instruction register (first bit shifted lands in bit 0)
    localparam logic [4:0] IR_CFG_IN = 5'h05;
    localparam logic [4:0] IR_STARTUP = 5'h0C;
    localparam logic [4:0] IR_CFG_OUT = 5'h04;
    localparam logic [4:0] IR_BYPASS = 5'h1F;
    localparam logic [4:0] IR_CAPTURE = 5'h01;

    // test clocks in shift-dr that run the startup or shutdown sequence
    localparam logic [3:0] STARTUP_CLKS = 4'hC;

    // packet header fields
    localparam logic [2:0] HDR_TYPE1 = 3'h1;
    localparam logic [1:0] OP_READ = 2'h1;
    localparam logic [1:0] OP_WRITE = 2'h2;

    // internal configuration register addresses
    localparam logic [4:0] REG_CRC = 5'h00;
    localparam logic [4:0] REG_FAR = 5'h01;
    localparam logic [4:0] REG_FDRI = 5'h02;
    localparam logic [4:0] REG_FRAME_OUT = 5'h03;
    localparam logic [4:0] REG_CMD = 5'h04;
    localparam logic [4:0] REG_STAT = 5'h07;
    localparam logic [4:0] REG_OPTION = 5'h09;

    // command register codes
    localparam logic [3:0] CMD_WCFG = 4'h1;
    localparam logic [3:0] CMD_READ_CFG = 4'h4;
    localparam logic [3:0] CMD_START = 4'h5;
    localparam logic [3:0] CMD_CRC_RESET = 4'h7;
    localparam logic [3:0] CMD_GLOBAL_HIGH = 4'h8;

    // option register shutdown bit
    localparam int OPT_SHUTDOWN_BIT = 15;

    // status word: fixed bits plus live flags
    localparam logic [15:0] STAT_CONST = 16'h075E;
    localparam int STAT_CRC_BIT = 0;
    localparam int STAT_ACTIVE_BIT = 11;
    localparam int STAT_GHIGH_N_BIT = 12;
    localparam int STAT_INIT_BIT = 13;
    localparam int STAT_DONE_BIT = 14;

    // ahb register byte addresses and reset values
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_FAR = 8'h08;
    localparam logic [7:0] CTRL_FRAME_RESET = 8'h04;

    typedef enum logic [3:0] {
        TAP_TLR, TAP_RTI, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PA_DR, TAP_EX2_DR,
        TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PA_IR, TAP_EX2_IR, TAP_UPD_IR
    } jcr_tap_type;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
        logic program_n;
    } jcr_pins_type;

    typedef struct packed {
        logic [2:0] kind;
        logic [1:0] op;
        logic [8:0] rsv_hi;
        logic [4:0] addr;
        logic [1:0] rsv_lo;
        logic [10:0] count;
    } jcr_hdr_type;

    typedef struct packed {
        jcr_tap_type tap_state;
        logic [4:0] ir_sh;
        logic [4:0] ir;
        logic byp;
        logic [31:0] word_sh;
        logic [4:0] bit_cnt;
        logic word_valid;
        logic [31:0] out_sh;
        logic [7:0] gar_cnt;
        logic [7:0] rb_addr;
        logic [10:0] rb_left;
        logic rd_stat;
        logic [3:0] start_cnt;
        logic tdo;
        logic tdo_oe;
        logic tck_q;
        logic [4:0] pp_addr;
        logic [10:0] pp_left;
        logic [7:0] frame_address_register;
        logic [31:0] crc;
        logic crc_err;
        logic wcfg;
        logic rd_cfg;
        logic start_seen;
        logic shutdown;
        logic active;
        logic done;
        logic ghigh;
        logic init_oe;
    } jcr_eng_type;

    localparam jcr_eng_type ENG_RESET = '{tap_state: TAP_TLR, ir_sh: IR_CAPTURE, ir: IR_BYPASS,
        ghigh: 1'b1, default: '0};

    typedef struct packed {
        logic dp_valid;
        logic dp_write;
        logic [7:0] dp_addr;
        logic [7:0] frame_words;
        logic [31:0] hrdata;
    } jcr_ahb_type;

    localparam jcr_ahb_type AHB_RESET = '{frame_words: CTRL_FRAME_RESET, default: '0};

    function automatic jcr_tap_type tap_next(input jcr_tap_type s, input logic tms);
        unique case (s)
            TAP_TLR: tap_next = tms ? TAP_TLR : TAP_RTI;
            TAP_RTI: tap_next = tms ? TAP_SEL_DR : TAP_RTI;
            TAP_SEL_DR: tap_next = tms ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: tap_next = tms ? TAP_EX1_DR : TAP_SH_DR;
            TAP_SH_DR: tap_next = tms ? TAP_EX1_DR : TAP_SH_DR;
            TAP_EX1_DR: tap_next = tms ? TAP_UPD_DR : TAP_PA_DR;
            TAP_PA_DR: tap_next = tms ? TAP_EX2_DR : TAP_PA_DR;
            TAP_EX2_DR: tap_next = tms ? TAP_UPD_DR : TAP_SH_DR;
            TAP_UPD_DR: tap_next = tms ? TAP_SEL_DR : TAP_RTI;
            TAP_SEL_IR: tap_next = tms ? TAP_TLR : TAP_CAP_IR;
            TAP_CAP_IR: tap_next = tms ? TAP_EX1_IR : TAP_SH_IR;
            TAP_SH_IR: tap_next = tms ? TAP_EX1_IR : TAP_SH_IR;
            TAP_EX1_IR: tap_next = tms ? TAP_UPD_IR : TAP_PA_IR;
            TAP_PA_IR: tap_next = tms ? TAP_EX2_IR : TAP_PA_IR;
            TAP_EX2_IR: tap_next = tms ? TAP_UPD_IR : TAP_SH_IR;
            TAP_UPD_IR: tap_next = tms ? TAP_SEL_DR : TAP_RTI;
        endcase
    endfunction : tap_next

    function automatic logic [31:0] crc_step(input logic [31:0] crc, input logic [31:0] data);
        crc_step = {crc[30:0], crc[31]} ^ data;
    endfunction : crc_step

endpackage : jcr_pkg

// [core/jcr_sync.sv]
`timescale 1ns/1ns
module jcr_sync #(
    parameter int W = 4
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    // asynchronous levels in, filtered levels out
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] next_q;

    // a bit moves only once stages two and three agree
    always_comb begin
        next_q = (~(s2 ^ s3) & s2) | ((s2 ^ s3) & q_o);
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            q_o <= '0;
        end else begin
            s1 <= d_i;
            s2 <= s1;
            s3 <= s2;
            q_o <= next_q;
        end
    end
endmodule : jcr_sync

// [verification/jcr_assertions.sv]
`timescale 1ns/1ns
module jcr_assertions (
    // system
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    // test port
    input wire logic tck_i,
    input wire logic program_n_i,
    input wire logic tdo_o,
    input wire logic tdo_oe_o,
    // status pins
    input wire logic done_o,
    input wire logic init_n_oe_o,
    input wire logic global_high_o,
    // ahb
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic hreadyout_o,
    input wire logic hresp_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rstn_i);
    logic take;
    assign take = hsel_i && hready_i && htrans_i[1] && !hwrite_i;
    chk_prog_holds: assert property ((!program_n_i) [*6] |-> !tdo_oe_o && !done_o && global_high_o)
        else $error("program low did not hold the port in reset");
    chk_init_quiet: assert property (program_n_i [*8] |-> !init_n_oe_o)
        else $error("init pulled low without program");
    chk_done_active: assert property (done_o |-> !global_high_o)
        else $error("done high while global high held");
    chk_tdo_fall: assert property ($changed(tdo_o) |-> !$past(tck_i, 2))
        else $error("tdo changed away from a test clock fall");
    chk_oe_fall: assert property ($rose(tdo_oe_o) |-> !$past(tck_i, 2))
        else $error("tdo enable rose away from a test clock fall");
    chk_done_rise: assert property ($rose(done_o) |-> $past(tck_i, 2))
        else $error("done rose away from a test clock rise");
    chk_rdata_hold: assert property (!$past(take) |-> $stable(hrdata_o))
        else $error("read data changed without a read");
    chk_unmapped_zero: assert property (take && haddr_i > 32'h8 |=> hrdata_o == 32'h0)
        else $error("unmapped read not zero");
    chk_status_live: assert property (take && haddr_i == 32'h4 |=>
        hrdata_o[0] == $past(done_o) && hrdata_o[2] == $past(global_high_o))
        else $error("status word disagrees with pins");
    chk_resp_okay: assert property (hreadyout_o && !hresp_o)
        else $error("bus response not ready and okay");
endmodule : jcr_assertions

bind jcr_config_port jcr_assertions i_chk (.clk_sys_i, .rstn_i, .tck_i, .program_n_i, .tdo_o, .tdo_oe_o,
    .done_o, .init_n_oe_o, .global_high_o, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hready_i, .hrdata_o,
    .hreadyout_o, .hresp_o);

// [verification/jcr_tap_ctl.sv]
`timescale 1ns/1ns
module jcr_tap_ctl
    import jcr_pkg::*;
(
    // clock
    input wire logic clk_sys_i,
    // test port
    output logic tck_o,
    output logic tms_o,
    output logic tdi_o,
    input wire logic tdo_i
);
    logic [31:0] rd = 32'h0;
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b0;
    end
    // 320 ns period; tck rests low between frames
    task automatic tclk(input logic ms, input logic di);
        @(posedge clk_sys_i);
        tms_o <= ms;
        tdi_o <= di;
        repeat (3) @(posedge clk_sys_i);
        tck_o <= 1'b1;
        // tdo lands five system clocks after the fall, so look late in the high phase
        repeat (3) @(posedge clk_sys_i);
        rd = {rd[30:0], tdo_i};
        @(posedge clk_sys_i);
        tck_o <= 1'b0;
    endtask : tclk
    task automatic walk(input logic [7:0] ms, input int n);
        for (int i = 0; i < n; i++) tclk(ms[i], 1'b0);
    endtask : walk
    task automatic treset();
        walk(8'h1F, 6);
    endtask : treset
    task automatic ir(input logic [4:0] code);
        walk(8'h03, 4);
        for (int i = 0; i < 5; i++) tclk(i == 4, code[i]);
        walk(8'h01, 2);
    endtask : ir
    task automatic dw(input logic [31:0] w, input int n, input logic ex);
        for (int i = n - 1; i >= 0; i--) tclk(ex && i == 0, w[i]);
    endtask : dw
    // ends in run-test/idle after every frame
    task automatic dr(input logic [31:0] q[$]);
        walk(8'h01, 3);
        foreach (q[i]) dw(q[i], 32, i == q.size() - 1);
        walk(8'h01, 2);
    endtask : dr
    task automatic startup();
        ir(IR_STARTUP);
        walk(8'h01, 3);
        dw(32'h0, 12, 1'b1);
        walk(8'h01, 2);
    endtask : startup
endmodule : jcr_tap_ctl

// [verification/testbench.sv]
`timescale 1ns/1ns
module testbench;
    import jcr_pkg::*;
    localparam logic [31:0] D0 = 32'hA5A5_0001;
    localparam logic [31:0] D1 = 32'h5A5A_0002;
    logic clk_sys_i = 1'b0;
    logic rstn_i = 1'b0;
    logic program_n_i = 1'b1;
    logic hsel_i = 1'b0;
    logic [31:0] haddr_i = 32'h0;
    logic [1:0] htrans_i = 2'h0;
    logic hwrite_i = 1'b0;
    logic [2:0] hsize_i = 3'h2;
    logic [31:0] hwdata_i = 32'h0;
    logic tck_i, tms_i, tdi_i, tdo_o, tdo_oe_o, done_o, init_n_o, init_n_oe_o, global_high_o;
    logic hready_i, hreadyout_o, hresp_o, tdo_w;
    logic [31:0] hrdata_o;
    logic [31:0] rv;
    logic [31:0] q[$];
    int n_mismatch = 0;
    int num_checks = 0;
    always #20 clk_sys_i = ~clk_sys_i;
    assign hready_i = hreadyout_o;
    // pull-up on a released tdo
    assign tdo_w = tdo_oe_o ? tdo_o : 1'b1;
    jcr_config_port i_dut (.clk_sys_i, .rstn_i, .tck_i, .tms_i, .tdi_i, .program_n_i, .tdo_o, .tdo_oe_o,
        .done_o, .init_n_o, .init_n_oe_o, .global_high_o, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i,
        .hwdata_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o);
    jcr_tap_ctl i_ctl (.clk_sys_i(clk_sys_i), .tck_o(tck_i), .tms_o(tms_i), .tdi_o(tdi_i), .tdo_i(tdo_w));
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic hwait();
        int t;
        t = 0;
        @(posedge clk_sys_i);
        while (hready_i !== 1'b1) begin
            t++;
            if (t > 20) begin
                n_mismatch++;
                print_verdict();
            end
            @(posedge clk_sys_i);
        end
    endtask : hwait
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel_i <= 1'b1;
        htrans_i <= 2'h2;
        haddr_i <= {24'h0, a};
        hwrite_i <= w;
        hwait();
        hsel_i <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= d;
        hwait();
        rv = hrdata_o;
    endtask : ahb
    function automatic logic [31:0] h(input logic [1:0] op, input logic [4:0] r, input logic [10:0] c);
        h = {HDR_TYPE1, op, 9'h0, r, 2'h0, c};
    endfunction : h
    task automatic t_config();
        i_ctl.treset();
        i_ctl.ir(IR_CFG_IN);
        q = {32'h0, h(OP_WRITE, REG_CMD, 1), 32'(CMD_WCFG), h(OP_WRITE, REG_FAR, 1), 32'h0,
            h(OP_WRITE, REG_FDRI, 2), D0, D1, h(OP_WRITE, REG_CMD, 1), 32'(CMD_START)};
        i_ctl.dr(q);
        chk("done early", 32'h0, 32'(done_o));
        i_ctl.startup();
        chk("done", 32'h1, 32'(done_o));
        chk("global high", 32'h0, 32'(global_high_o));
        ahb(1'b0, ADDR_STATUS, 32'h0);
        chk("status", 32'h1, {29'h0, rv[2:0]});
        ahb(1'b0, ADDR_FAR, 32'h0);
        chk("frame address", 32'h2, rv);
    endtask : t_config
    task automatic t_status(input logic [31:0] e, input logic [31:0] m);
        i_ctl.treset();
        i_ctl.ir(IR_CFG_IN);
        q = {h(OP_READ, REG_STAT, 1), 32'h0};
        i_ctl.dr(q);
        i_ctl.ir(IR_CFG_OUT);
        i_ctl.walk(8'h01, 3);
        i_ctl.dw(32'h0, 32, 1'b1);
        chk("status word", e, i_ctl.rd & m);
        i_ctl.walk(8'h01, 2);
    endtask : t_status
    task automatic t_crc();
        i_ctl.ir(IR_CFG_IN);
        q = {h(OP_WRITE, REG_CRC, 1), 32'hFFFF_FFFF};
        i_ctl.dr(q);
        t_status(32'h1, 32'h1);
        i_ctl.ir(IR_CFG_IN);
        q = {h(OP_WRITE, REG_CMD, 1), 32'(CMD_CRC_RESET)};
        i_ctl.dr(q);
        ahb(1'b0, ADDR_STATUS, 32'h0);
        chk("checksum error cleared", 32'h0, {31'h0, rv[1]});
    endtask : t_crc
    task automatic t_shutdown();
        i_ctl.ir(IR_CFG_IN);
        q = {h(OP_WRITE, REG_OPTION, 1), 32'h0000_8000, h(OP_WRITE, REG_CMD, 1), 32'(CMD_START),
            h(OP_WRITE, REG_CMD, 1), 32'(CMD_CRC_RESET)};
        i_ctl.dr(q);
        i_ctl.startup();
        chk("done after shutdown", 32'h0, 32'(done_o));
        i_ctl.ir(IR_CFG_IN);
        q = {h(OP_WRITE, REG_CMD, 1), 32'(CMD_GLOBAL_HIGH), h(OP_WRITE, REG_OPTION, 1), 32'h0};
        i_ctl.dr(q);
        chk("global high", 32'h1, 32'(global_high_o));
    endtask : t_shutdown
    task automatic t_program();
        program_n_i <= 1'b0;
        repeat (10) @(posedge clk_sys_i);
        ahb(1'b0, ADDR_STATUS, 32'h0);
        chk("tap held", 32'h0, {28'h0, rv[11:8]});
        chk("status", 32'h4, {29'h0, rv[2:0]});
        program_n_i <= 1'b1;
        repeat (10) @(posedge clk_sys_i);
        chk("init pull", 32'h0, 32'(init_n_oe_o));
    endtask : t_program
    task automatic t_readback();
        ahb(1'b1, ADDR_CTRL, 32'h1);
        ahb(1'b0, ADDR_CTRL, 32'h0);
        chk("frame words", 32'h1, rv);
        ahb(1'b0, 8'h10, 32'h0);
        chk("unmapped", 32'h0, rv);
        // the program pulse left the tap in reset
        i_ctl.treset();
        for (int k = 0; k < 2; k++) begin
            // second pass starts one word in, as a block memory readback would
            i_ctl.ir(IR_CFG_IN);
            q = {h(OP_WRITE, REG_FAR, 1), 32'(k), h(OP_WRITE, REG_CMD, 1), 32'(CMD_READ_CFG),
                h(OP_READ, REG_FRAME_OUT, 11'(2 - k)), 32'h0};
            i_ctl.dr(q);
            i_ctl.ir(IR_CFG_OUT);
            i_ctl.walk(8'h01, 3);
            for (int i = 0; i < 4; i++) begin
                i_ctl.dw(32'h0, 32, i == 3);
                if (i > 1) chk("readback", i + k == 2 ? D0 : i + k == 3 ? D1 : 32'h0, i_ctl.rd);
            end
            i_ctl.walk(8'h01, 2);
        end
    endtask : t_readback
    initial begin
        repeat (90000) @(posedge clk_sys_i);
        n_mismatch++;
        print_verdict();
    end
    initial begin
        repeat (10) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        repeat (8) @(posedge clk_sys_i);
        t_config();
        t_status(32'h0000_7F5E, 32'hFFFF_FFFF);
        t_crc();
        t_shutdown();
        t_program();
        t_readback();
        print_verdict();
    end
endmodule : testbench
